// ===== hdl/tsec_pkg.sv
package tsec_pkg;

  // Sizes of the two stages.
  localparam int NSRC = 96;
  localparam int NWORD = 3;
  localparam int NASSIGN = 12;
  localparam int NGP = 7;
  localparam int NCLASS = 5;
  localparam int CODE_W = 4;

  // Register byte offsets.
  localparam logic [7:0] OFF_CORE_LATCH = 8'h00;
  localparam logic [7:0] OFF_CORE_MASK = 8'h04;
  localparam logic [7:0] OFF_CORE_PEND = 8'h08;
  localparam logic [7:0] OFF_CORE_CTRL = 8'h0c;
  localparam logic [7:0] OFF_SYS_MASK = 8'h10;
  localparam logic [7:0] OFF_SYS_STAT = 8'h1c;
  localparam logic [7:0] OFF_STAT_END = 8'h28;
  localparam logic [7:0] OFF_ASSIGN = 8'h40;
  localparam logic [7:0] OFF_ASSIGN_END = 8'h70;

  // Reset values and fixed fields.
  localparam logic [15:0] CORE_LATCH_RST = 16'h0000;
  localparam logic [15:0] CORE_MASK_RST = 16'h000f;
  localparam logic [15:0] CORE_MASK_FIX = 16'h000f;
  localparam logic [15:0] CORE_MASK_WR = 16'hffe0;
  localparam logic [31:0] SYS_MASK_RST = 32'h0000_0000;
  localparam int CTRL_GIE_BIT = 0;
  localparam logic CTRL_GIE_RST = 1'b1;

  // Fixed core priorities, 0 is highest.
  localparam logic [3:0] LVL_EMULATION = 4'h0;
  localparam logic [3:0] LVL_RESET = 4'h1;
  localparam logic [3:0] LVL_NMI = 4'h2;
  localparam logic [3:0] LVL_EXCEPTION = 4'h3;
  localparam logic [3:0] LVL_RESERVED = 4'h4;
  localparam logic [3:0] LVL_HW_ERROR = 4'h5;
  localparam logic [3:0] LVL_CORE_TIMER = 4'h6;
  localparam logic [3:0] LVL_GP_BASE = 4'h7;
  localparam logic [4:0] LVL_NONE = 5'h10;
  localparam logic [2:0] CODE_MAX = 3'h6;

  // Shared and watchdog peripheral source identifiers.
  localparam int SRC_WATCHDOG = 23;
  localparam int SRC_DMA_SHARED = 63;

  // Default assignment codes, one nibble per source, lowest id low.
  localparam logic [31:0] ASSIGN_RST [NASSIGN] = '{
    32'h1000_0000, 32'h3332_2221, 32'h6665_5444, 32'h0000_0000,
    32'h3222_2220, 32'h4443_3333, 32'h0044_4664, 32'h0000_0000,
    32'h4411_1111, 32'h4444_4444, 32'h4444_4444, 32'h5544_4444};

  typedef struct packed {
    logic valid;
    logic [3:0] level;
  } tsec_offer_type;

endpackage

// ===== hdl/tsec_sys_stage.sv
`timescale 1ns/1ps
`default_nettype none

module tsec_sys_stage import tsec_pkg::*; (
  input wire logic clk, // Clock, used by the checks only.
  input wire logic rstn, // Reset, used by the checks only.
  input wire logic [NSRC-1:0] src, // Synchronised source levels.
  input wire logic [NSRC-1:0] mask, // Set bit forwards the source.
  input wire logic [NSRC*CODE_W-1:0] codes, // Assignment code per source.
  output logic [NGP-1:0] gp_req // Requests for levels 7 to 13.
);

  // Codes above six route nowhere.
  always_comb begin
    gp_req = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (src[i] && mask[i] && codes[CODE_W*i+3] == 1'b0
          && codes[CODE_W*i +: 3] <= CODE_MAX) begin
        gp_req[codes[CODE_W*i +: 3]] = 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_masked_quiet;
    (mask == '0) |-> (gp_req == '0);
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("masked sources still raise a level");

  property p_wdog_route;
    (src[SRC_WATCHDOG] && mask[SRC_WATCHDOG]
     && codes[CODE_W*SRC_WATCHDOG +: CODE_W] == 4'h6) |-> gp_req[6];
  endproperty
  a_wdog_route: assert property (p_wdog_route)
    else $error("code six does not reach level thirteen");

endmodule // tsec_sys_stage

`default_nettype wire

// ===== hdl/tsec_top.sv
`timescale 1ns/1ps
`default_nettype none

module tsec_top import tsec_pkg::*; (
  input wire logic clk, // 50 MHz clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_we, // Register write strobe.
  input wire logic reg_re, // Register read strobe.
  output logic [31:0] reg_rdata, // Read data, cycle after strobe.
  input wire logic [NSRC-1:0] irq_src, // Peripheral requests, async.
  input wire logic [3:0] dma_req_irq, // Shared DMA request sources.
  input wire logic nmi_pin, // Non-maskable pin, async.
  input wire logic wdog_nmi, // Watchdog non-maskable request.
  input wire logic emulation_req, // Test port request, async.
  input wire logic reset_req, // Reset event request, async.
  input wire logic exc_req, // Synchronous exception pulse.
  input wire logic hw_err, // Hardware error pulse.
  input wire logic core_tmr, // Core timer pulse.
  input wire logic raise_valid, // Software raise strobe.
  input wire logic [3:0] raise_level, // Level to raise.
  output tsec_offer_type event_offer, // Event offered to sequencer.
  input wire logic event_ack, // Sequencer takes the offer.
  input wire logic event_ret, // Return from innermost event.
  input wire logic [31:0] ret_pc, // Resume address at accept.
  output logic [31:0] ret_addr, // Return address, innermost.
  output logic save_state, // Push state on supervisor stack.
  output logic emulation_mode, // Core is in emulation mode.
  output logic proc_reset // Reset the processor, pulse.
);

  localparam int SW = NSRC + 7;

  logic [SW-1:0] sy1_r;
  logic [SW-1:0] sy2_r;
  logic nmi_d_r;
  logic nmi_s;
  logic emulation_s;
  logic rst_s;
  logic [NSRC-1:0] src_eff;
  logic [31:0] sys_mask_r [NWORD];
  logic [31:0] assign_r [NASSIGN];
  logic [NSRC-1:0] mask_flat;
  logic [NSRC*CODE_W-1:0] codes_flat;
  logic [NGP-1:0] gp_req;
  logic [15:0] latch_r;
  logic [15:0] latch_nxt;
  logic [15:0] mask_r;
  logic [15:0] pend_r;
  logic [15:0] pend_nxt;
  logic gie_r;
  logic [15:0] en;
  logic [15:0] cand;
  logic [15:0] set_vec;
  logic [4:0] cand_lvl;
  logic [4:0] top_pend;
  logic accept;
  logic [31:0] ret_arr_r [NCLASS];
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic save_r;
  logic emulation_mode_r;
  logic preset_r;
  logic [31:0] ret_addr_r;
  logic hit_latch;
  logic hit_mask;
  logic hit_pend;
  logic hit_ctrl;
  logic hit_smask;
  logic hit_sstat;
  logic hit_asg;
  logic [1:0] sm_idx;
  logic [1:0] ss_idx;
  logic [3:0] as_idx;

  function automatic logic [4:0] first_set(input logic [15:0] v);
    first_set = LVL_NONE;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  function automatic logic [2:0] class_of(input logic [4:0] lvl);
    class_of = (lvl < 5'(LVL_RESERVED)) ? lvl[2:0] : 3'h4;
  endfunction

  // Pins and foreign-domain requests pass two flip-flops first.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sy1_r <= '0;
      sy2_r <= '0;
      nmi_d_r <= 1'b0;
    end else begin
      sy1_r <= {reset_req, emulation_req, nmi_pin, dma_req_irq, irq_src};
      sy2_r <= sy1_r;
      nmi_d_r <= nmi_s;
    end
  end

  always_comb begin
    nmi_s = sy2_r[NSRC+4];
    emulation_s = sy2_r[NSRC+5];
    rst_s = sy2_r[NSRC+6];
    src_eff = sy2_r[NSRC-1:0];
    src_eff[SRC_DMA_SHARED] = sy2_r[SRC_DMA_SHARED]
                              | (|sy2_r[NSRC+3:NSRC]);
  end

  always_comb begin
    for (int w = 0; w < NWORD; w++) begin
      mask_flat[32*w +: 32] = sys_mask_r[w];
    end
    for (int r = 0; r < NASSIGN; r++) begin
      codes_flat[32*r +: 32] = assign_r[r];
    end
  end

  tsec_sys_stage i_tsec_sys_stage (
    .clk(clk),
    .rstn(rstn),
    .src(src_eff),
    .mask(mask_flat),
    .codes(codes_flat),
    .gp_req(gp_req)
  );

  // Register decode; misaligned addresses hit nothing.
  always_comb begin
    hit_latch = reg_addr == OFF_CORE_LATCH;
    hit_mask = reg_addr == OFF_CORE_MASK;
    hit_pend = reg_addr == OFF_CORE_PEND;
    hit_ctrl = reg_addr == OFF_CORE_CTRL;
    hit_smask = reg_addr >= OFF_SYS_MASK && reg_addr < OFF_SYS_STAT
                && reg_addr[1:0] == 2'h0;
    hit_sstat = reg_addr >= OFF_SYS_STAT && reg_addr < OFF_STAT_END
                && reg_addr[1:0] == 2'h0;
    hit_asg = reg_addr >= OFF_ASSIGN && reg_addr < OFF_ASSIGN_END
              && reg_addr[1:0] == 2'h0;
    sm_idx = 2'((reg_addr - OFF_SYS_MASK) >> 2);
    ss_idx = 2'((reg_addr - OFF_SYS_STAT) >> 2);
    as_idx = 4'((reg_addr - OFF_ASSIGN) >> 2);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int w = 0; w < NWORD; w++) begin
        sys_mask_r[w] <= SYS_MASK_RST;
      end
    end else if (reg_we && hit_smask) begin
      sys_mask_r[sm_idx] <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int r = 0; r < NASSIGN; r++) begin
        assign_r[r] <= ASSIGN_RST[r];
      end
    end else if (reg_we && hit_asg) begin
      assign_r[as_idx] <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_r <= CORE_MASK_RST;
      gie_r <= CTRL_GIE_RST;
    end else begin
      if (reg_we && hit_mask) begin
        mask_r <= (reg_wdata[15:0] & CORE_MASK_WR) | CORE_MASK_FIX;
      end
      if (reg_we && hit_ctrl) begin
        gie_r <= reg_wdata[CTRL_GIE_BIT];
      end
    end
  end

  // Events raised this cycle; level sources relatch only when idle.
  always_comb begin
    set_vec = '0;
    set_vec[LVL_EMULATION] = emulation_s & ~pend_r[LVL_EMULATION];
    set_vec[LVL_RESET] = rst_s & ~pend_r[LVL_RESET];
    set_vec[LVL_NMI] = (nmi_s & ~nmi_d_r) | wdog_nmi;
    set_vec[LVL_EXCEPTION] = exc_req;
    set_vec[LVL_HW_ERROR] = hw_err;
    set_vec[LVL_CORE_TIMER] = core_tmr;
    set_vec[LVL_GP_BASE +: NGP] = gp_req & ~pend_r[LVL_GP_BASE +: NGP];
    if (raise_valid && raise_level != LVL_RESERVED) begin
      set_vec[raise_level] = 1'b1;
    end
  end

  // Global enable gates only general levels; classes below 4 never mask.
  always_comb begin
    en = mask_r & {{9{gie_r}}, 7'h6f};
    cand = latch_r & en;
    cand_lvl = first_set(cand);
    top_pend = first_set(pend_r);
    event_offer.valid = cand_lvl < top_pend;
    event_offer.level = cand_lvl[3:0];
    accept = event_ack && event_offer.valid;
  end

  // A hardware set wins over both accept and software clear.
  always_comb begin
    latch_nxt = latch_r;
    if (accept) begin
      latch_nxt[event_offer.level] = 1'b0;
    end
    if (reg_we && hit_latch) begin
      latch_nxt = (latch_nxt & mask_r) | (reg_wdata[15:0] & ~mask_r);
    end
    latch_nxt = latch_nxt | set_vec;
    latch_nxt[LVL_RESERVED] = 1'b0;
  end

  always_comb begin
    pend_nxt = pend_r;
    if (event_ret && top_pend != LVL_NONE) begin
      pend_nxt[top_pend[3:0]] = 1'b0;
    end
    if (accept) begin
      pend_nxt[event_offer.level] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_r <= CORE_LATCH_RST;
      pend_r <= '0;
    end else begin
      latch_r <= latch_nxt;
      pend_r <= pend_nxt;
    end
  end

  // Return addresses are kept per event class.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NCLASS; c++) begin
        ret_arr_r[c] <= '0;
      end
      ret_addr_r <= '0;
    end else begin
      if (accept) begin
        ret_arr_r[class_of({1'b0, event_offer.level})] <= ret_pc;
      end
      ret_addr_r <= ret_arr_r[class_of(top_pend)];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      save_r <= 1'b0;
      preset_r <= 1'b0;
      emulation_mode_r <= 1'b0;
    end else begin
      save_r <= accept;
      preset_r <= accept && event_offer.level == LVL_RESET;
      if (accept && event_offer.level == LVL_EMULATION) begin
        emulation_mode_r <= 1'b1;
      end else if (event_ret && top_pend == 5'(LVL_EMULATION)) begin
        emulation_mode_r <= 1'b0;
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_comb begin
    rdata_nxt = '0;
    if (reg_re) begin
      if (hit_latch) begin
        rdata_nxt = {16'h0000, latch_r};
      end else if (hit_mask) begin
        rdata_nxt = {16'h0000, mask_r};
      end else if (hit_pend) begin
        rdata_nxt = {16'h0000, pend_r};
      end else if (hit_ctrl) begin
        rdata_nxt = {31'h0, gie_r};
      end else if (hit_smask) begin
        rdata_nxt = sys_mask_r[sm_idx];
      end else if (hit_sstat) begin
        rdata_nxt = src_eff[32*ss_idx +: 32];
      end else if (hit_asg) begin
        rdata_nxt = assign_r[as_idx];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    reg_rdata = rdata_r;
    ret_addr = ret_addr_r;
    save_state = save_r;
    emulation_mode = emulation_mode_r;
    proc_reset = preset_r;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_highest_first;
    event_offer.valid |-> ((cand & ((16'h1 << event_offer.level) - 16'h1))
                           == 16'h0);
  endproperty
  a_highest_first: assert property (p_highest_first)
    else $error("a higher enabled event was passed over");

  property p_nest_only_higher;
    event_offer.valid
      |-> ((pend_r & ((16'h2 << event_offer.level) - 16'h1)) == 16'h0);
  endproperty
  a_nest_only_higher: assert property (p_nest_only_higher)
    else $error("offer does not preempt the active event");

  property p_accept_pends;
    accept |=> pend_r[$past(event_offer.level)] && save_state
               && ret_arr_r[class_of({1'b0, $past(event_offer.level)})]
                  == $past(ret_pc);
  endproperty
  a_accept_pends: assert property (p_accept_pends)
    else $error("accepted event not marked active with state save");

  property p_masked_not_offered;
    event_offer.valid |-> en[event_offer.level];
  endproperty
  a_masked_not_offered: assert property (p_masked_not_offered)
    else $error("masked event offered");

  property p_reset_second;
    (latch_r[LVL_RESET] && !latch_r[LVL_EMULATION] && pend_r[1:0] == 2'h0)
      |-> (event_offer.valid && event_offer.level == LVL_RESET);
  endproperty
  a_reset_second: assert property (p_reset_second)
    else $error("reset event not offered at priority one");

  property p_reserved_idle;
    !latch_r[LVL_RESERVED] && !(event_offer.valid
                                && event_offer.level == LVL_RESERVED);
  endproperty
  a_reserved_idle: assert property (p_reserved_idle)
    else $error("reserved priority became active");

  property p_emulation_enter;
    (accept && event_offer.level == LVL_EMULATION) |=> emulation_mode;
  endproperty
  a_emulation_enter: assert property (p_emulation_enter)
    else $error("emulation accept did not enter emulation mode");

  property p_nmi_pin_latch;
    (nmi_s && !nmi_d_r) |=> latch_r[LVL_NMI] || pend_r[LVL_NMI];
  endproperty
  a_nmi_pin_latch: assert property (p_nmi_pin_latch)
    else $error("pin edge did not latch the non-maskable event");

  property p_wdog_default;
    $rose(rstn) |-> assign_r[2][31:28] == 4'h6 && assign_r[6][23:20] == 4'h4;
  endproperty
  a_wdog_default: assert property (p_wdog_default)
    else $error("default assignment wrong after reset");

  c_nested: cover property (accept && pend_r != 16'h0);
  c_reset_taken: cover property (accept && event_offer.level == LVL_RESET);
  c_general_seven: cover property (accept && event_offer.level == 4'h7);
  c_return: cover property (event_ret ##1 event_offer.valid);

endmodule // tsec_top

`default_nettype wire

// ===== testbench/tsec_seq_model.sv
`timescale 1ns/1ps
`default_nettype none

module tsec_seq_model import tsec_pkg::*; (
  input wire logic clk, // Clock.
  input wire logic rstn, // Reset, active low.
  input wire tsec_offer_type offer, // Event offered by the controller.
  input wire logic ack_en, // Lets the model take offers.
  input wire logic [1:0] delay, // Cycles to wait before taking.
  output logic event_ack, // Takes the current offer.
  output logic [31:0] ret_pc, // Resume address, moves every cycle.
  output logic [31:0] last_pc // Resume address handed at the last take.
);
  logic [1:0] wait_r;

  // The ack is dropped after one cycle so the same offer is never taken twice.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_ack <= 1'b0;
      wait_r <= 2'h0;
      last_pc <= 32'h0000_0000;
    end else if (event_ack) begin
      event_ack <= 1'b0;
      wait_r <= 2'h0;
      last_pc <= ret_pc;
    end else if (ack_en && offer.valid) begin
      if (wait_r >= delay) begin
        event_ack <= 1'b1;
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end else begin
      wait_r <= 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ret_pc <= 32'h0000_1000;
    end else begin
      ret_pc <= ret_pc + 32'h0000_0004;
    end
  end
endmodule // tsec_seq_model

`default_nettype wire

// ===== testbench/test_tsec_top.sv
`timescale 1ns/1ps
`default_nettype none

module test_tsec_top import tsec_pkg::*;;
  logic clk, rstn, reg_we, reg_re, nmi_pin, wdog_nmi, emulation_req;
  logic reset_req, exc_req, hw_err, core_tmr, raise_valid, event_ack;
  logic event_ret, save_state, emulation_mode, proc_reset, ack_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ret_pc, ret_addr, last_pc, d;
  logic [NSRC-1:0] irq_src;
  logic [3:0] dma_req_irq, raise_level;
  logic [1:0] delay;
  tsec_offer_type event_offer;
  int error_cnt, check_count;

  always #10 clk = ~clk;

  tsec_top i_tsec_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .irq_src(irq_src), .dma_req_irq(dma_req_irq),
    .nmi_pin(nmi_pin), .wdog_nmi(wdog_nmi), .emulation_req(emulation_req),
    .reset_req(reset_req), .exc_req(exc_req), .hw_err(hw_err),
    .core_tmr(core_tmr), .raise_valid(raise_valid),
    .raise_level(raise_level), .event_offer(event_offer),
    .event_ack(event_ack), .event_ret(event_ret), .ret_pc(ret_pc),
    .ret_addr(ret_addr), .save_state(save_state),
    .emulation_mode(emulation_mode), .proc_reset(proc_reset));

  tsec_seq_model i_tsec_seq_model (.clk(clk), .rstn(rstn),
    .offer(event_offer), .ack_en(ack_en), .delay(delay),
    .event_ack(event_ack), .ret_pc(ret_pc), .last_pc(last_pc));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_offer(input logic [3:0] lvl, input string what);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (event_offer.valid !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(what, {27'h0, 1'b1, lvl}, {27'h0, event_offer});
  endtask

  // The take is seen through the state-save pulse that follows an accept.
  task automatic take(input string what);
    int n;
    n = 0;
    @(posedge clk);
    ack_en <= 1'b1;
    #1;
    while (save_state !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    ack_en <= 1'b0;
    chk(what, 32'h1, {31'h0, save_state});
  endtask

  task automatic ret_one;
    @(posedge clk);
    event_ret <= 1'b1;
    @(posedge clk);
    event_ret <= 1'b0;
  endtask

  task automatic drive_src(input int s, input logic v);
    @(posedge clk);
    if (s == SRC_DMA_SHARED) dma_req_irq[2] <= v;
    else irq_src[s] <= v;
  endtask

  task automatic route(input int s, input logic [3:0] lvl);
    logic [7:0] w;
    w = 8'(4 * (s / 32));
    drive_src(s, 1'b1);
    tick(6);
    #1;
    chk("masked source", 32'h0, {31'h0, event_offer.valid});
    wr(OFF_SYS_MASK + w, 32'h1 << (s % 32));
    wait_offer(lvl, "routed level");
    rd(OFF_SYS_STAT + w);
    chk("source status", 32'h1 << (s % 32), d);
    drive_src(s, 1'b0);
    take("routed take");
    tick(4);
    ret_one;
    wr(OFF_SYS_MASK + w, 32'h0);
  endtask

  task automatic t_reset;
    chk("offer at reset", 32'h0, {31'h0, event_offer.valid});
    chk("mode at reset", 32'h0, {31'h0, emulation_mode});
    rd(OFF_CORE_MASK);
    chk("core mask", 32'h0000_000f, d);
    rd(OFF_CORE_LATCH);
    chk("core latch", 32'h0, d);
    rd(OFF_SYS_MASK + 8'h04);
    chk("system mask", 32'h0, d);
    rd(8'h48);
    chk("code 23", 32'h6, {28'h0, d[31:28]});
    rd(8'h4c);
    chk("code 27", 32'h0, {28'h0, d[15:12]});
    rd(8'h58);
    chk("code 53", 32'h4, {28'h0, d[23:20]});
    rd(8'h5c);
    chk("code 59", 32'h0, {28'h0, d[15:12]});
    chk("code 63", 32'h0, {28'h0, d[31:28]});
    rd(8'h30);
    chk("unmapped read", 32'h0, d);
    @(posedge clk);
    #1;
    chk("read data released", 32'h0, reg_rdata);
    $display("reset test done");
  endtask

  task automatic t_priority;
    wr(OFF_CORE_MASK, 32'h0000_ffff);
    rd(OFF_CORE_MASK);
    chk("mask fixed bits", 32'h0000_ffef, d);
    @(posedge clk);
    exc_req <= 1'b1;
    hw_err <= 1'b1;
    core_tmr <= 1'b1;
    @(posedge clk);
    exc_req <= 1'b0;
    hw_err <= 1'b0;
    core_tmr <= 1'b0;
    rd(OFF_CORE_LATCH);
    chk("three latched", 32'h0000_0068, d);
    wait_offer(4'h3, "exception first");
    take("exception take");
    chk("no lower preempt", 32'h0, {31'h0, event_offer.valid});
    ret_one;
    wait_offer(4'h5, "hardware error next");
    take("hardware error take");
    @(posedge clk);
    exc_req <= 1'b1;
    @(posedge clk);
    exc_req <= 1'b0;
    wait_offer(4'h3, "nested exception");
    take("nested take");
    rd(OFF_CORE_PEND);
    chk("two active", 32'h0000_0028, d);
    ret_one;
    ret_one;
    wait_offer(4'h6, "timer last");
    take("timer take");
    ret_one;
    rd(OFF_CORE_PEND);
    chk("none active", 32'h0, d);
    $display("priority test done");
  endtask

  task automatic t_latch;
    wr(OFF_CORE_MASK, 32'h0000_feff);
    wr(OFF_CORE_LATCH, 32'h0000_0100);
    rd(OFF_CORE_LATCH);
    chk("latch write", 32'h0000_0100, d);
    chk("masked latched", 32'h0, {31'h0, event_offer.valid});
    wr(OFF_CORE_MASK, 32'h0000_ffff);
    wait_offer(4'h8, "unmasked event");
    wr(OFF_CORE_LATCH, 32'h0);
    rd(OFF_CORE_LATCH);
    chk("latch write refused", 32'h0000_0100, d);
    take("latched take");
    rd(OFF_CORE_LATCH);
    chk("latch cleared", 32'h0, d);
    ret_one;
    wr(OFF_CORE_CTRL, 32'h0);
    @(posedge clk);
    raise_valid <= 1'b1;
    raise_level <= 4'h9;
    @(posedge clk);
    raise_valid <= 1'b0;
    tick(1);
    #1;
    chk("global disable", 32'h0, {31'h0, event_offer.valid});
    rd(OFF_CORE_CTRL);
    chk("global enable bit", 32'h0, d);
    wr(OFF_CORE_CTRL, 32'h1);
    wait_offer(4'h9, "global enable");
    take("raised take");
    ret_one;
    $display("latch test done");
  endtask

  task automatic t_events;
    logic [3:0] lv [5];
    lv = '{4'h0, 4'h1, 4'h2, 4'h2, 4'he};
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      delay <= 2'(k);
      case (k)
        0: emulation_req <= 1'b1;
        1: reset_req <= 1'b1;
        2: nmi_pin <= 1'b1;
        3: wdog_nmi <= 1'b1;
        default: begin
          raise_valid <= 1'b1;
          raise_level <= 4'he;
        end
      endcase
      @(posedge clk);
      wdog_nmi <= 1'b0;
      raise_valid <= 1'b0;
      wait_offer(lv[k], "event level");
      // Level requests drop before the take so the accept edge does not
      // latch them again through the synchroniser.
      @(posedge clk);
      emulation_req <= 1'b0;
      reset_req <= 1'b0;
      nmi_pin <= 1'b0;
      take("event take");
      if (k == 0) chk("emulation", 32'h1, {31'h0, emulation_mode});
      if (k == 1) chk("core reset", 32'h1, {31'h0, proc_reset});
      @(posedge clk);
      #1;
      chk("return address", last_pc, ret_addr);
      ret_one;
      tick(1);
      #1;
      chk("mode after return", 32'h0, {31'h0, emulation_mode});
      chk("no stale offer", 32'h0, {31'h0, event_offer.valid});
    end
    $display("event test done");
  endtask

  task automatic t_periph;
    route(27, 4'h7);
    route(59, 4'h7);
    route(53, 4'hb);
    route(SRC_WATCHDOG, 4'hd);
    route(SRC_DMA_SHARED, 4'h7);
    wr(8'h4c, 32'h0000_2000);
    route(27, 4'h9);
    $display("peripheral test done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    wrap_up;
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {reg_we, reg_re, nmi_pin, wdog_nmi, emulation_req, reset_req} = '0;
    {exc_req, hw_err, core_tmr, raise_valid, event_ret, ack_en} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    irq_src = '0;
    dma_req_irq = 4'h0;
    raise_level = 4'h0;
    delay = 2'h0;
    error_cnt = 0;
    check_count = 0;
    tick(16);
    rstn <= 1'b1;
    t_reset;
    t_priority;
    t_latch;
    t_events;
    t_periph;
    wrap_up;
  end
endmodule // test_tsec_top

`default_nettype wire
